// [logic/blrs_top.sv]
/*
 Board status LED control and reset cause status registers on host I/O ports.
 Assumes single-cycle I/O strobes on core_clk and asynchronous board status inputs.
*/
// Summary of operation
// - Automatic mode: green normal, blue disk, red reset, yellow standby, white hot.
// - Automatic mode: cyan at 10 Mbps, magenta at 100 Mbps, blink on traffic.
// - White thermal indication latches until system shutdown.
// - Power-up with defaults jumper fitted shows red.
// - Host overrides LED by writing a colour code at port 456h.
// - Code 0x00 selects automatic; code 0x08 turns LED off.
// - Codes 0x09-0x0F force colours; bit0 blue, bit1 green, bit2 red.
// - A configuration input enables or disables the LED entirely.
// - Reading port 0x457 returns one for each asserted reset source.
// - Writing one to a reset status bit clears it; zero leaves it.
// - Bits: D7 main, D6 core, D5 non-standby, D4 memory, D3 standby, D1 PCI, D0 button.
// - Priorities: standby 1, main 2, core/non-standby/memory 3, PCI 4.
// - A flagged source also flags every source of larger priority number.
// - Push-button bit sets on any press, whatever its configured function.
`timescale 1ns/1ps
module blrs_top
  import blrs_pkg::*;
#(
  parameter int BLINK_CNT = BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic led_enable,
  input wire logic board_in_reset,
  input wire logic disk_active,
  input wire logic standby,
  input wire logic thermal_near,
  input wire logic system_shutdown,
  input wire logic net_link_10,
  input wire logic net_link_100,
  input wire logic net_activity,
  input wire logic defaults_jumper,
  input wire logic rst_main_pwr,
  input wire logic rst_core_pwr,
  input wire logic rst_nonstby_pwr,
  input wire logic rst_mem_pwr,
  input wire logic rst_stby_pwr,
  input wire logic rst_pci,
  input wire logic button_pressed,
  output logic led_red,
  output logic led_green,
  output logic led_blue
);
  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int NIN = 17;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;

  assign raw_in = {led_enable, board_in_reset, disk_active, standby, thermal_near,
                   system_shutdown, net_link_10, net_link_100, net_activity,
                   defaults_jumper, rst_main_pwr, rst_core_pwr, rst_nonstby_pwr,
                   rst_mem_pwr, rst_stby_pwr, rst_pci, button_pressed};

  blrs_sync #(.W(NIN)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic s_en, s_inrst, s_disk, s_stby, s_hot, s_shut, s_l10, s_l100, s_act, s_jmp;
  logic [6:0] s_src;
  assign {s_en, s_inrst, s_disk, s_stby, s_hot, s_shut, s_l10, s_l100, s_act, s_jmp} =
         syn[NIN-1:7];
  assign s_src = syn[6:0];

  // The synchroniser is cleared by reset, so the jumper is taken only once a real sample is out.
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [1:0] BOOT_SAMPLE = 2'h1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] led_code;
    logic [7:0] rst_stat;
    logic hot_latch;
    logic jmp_seen;
    logic [1:0] boot_cnt;
    logic blink_off;
    logic [31:0] blink_cnt;
    logic [2:0] color;
    logic [7:0] rdata;
    logic rvalid;
  } blrs_state_t;

  blrs_state_t st_r;
  blrs_state_t st_nxt;

  logic wr_led, wr_rst, rd_led, rd_rst;
  assign wr_led = io_wr && (io_addr == LED_CTRL_ADDR);
  assign wr_rst = io_wr && (io_addr == RST_STAT_ADDR);
  assign rd_led = io_rd && (io_addr == LED_CTRL_ADDR);
  assign rd_rst = io_rd && (io_addr == RST_STAT_ADDR);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] set_v;
    logic [2:0] auto_c;
    logic [2:0] col;
    set_v = 8'h00;
    auto_c = COL_GREEN;
    col = COL_OFF;
    st_nxt = st_r;
    if (st_r.boot_cnt != 2'h0)
      st_nxt.boot_cnt = st_r.boot_cnt - 2'h1;
    st_nxt.rvalid = 1'b0;
    if (wr_led)
    begin
      // Only the low nibble is held here; upper bits are ignored.
      if (io_wdata[LED_MANUAL_BIT])
        st_nxt.led_code = io_wdata[3:0];
      else
        st_nxt.led_code = LED_CODE_AUTO;
    end
    // Source flags with priority cascade to larger numbers.
    set_v[RS_STBY] = s_src[2];
    set_v[RS_MAIN] = s_src[6] || set_v[RS_STBY];
    set_v[RS_CORE] = s_src[5] || set_v[RS_MAIN];
    set_v[RS_NONSTBY] = s_src[4] || set_v[RS_MAIN];
    set_v[RS_MEM] = s_src[3] || set_v[RS_MAIN];
    set_v[RS_PCI] = s_src[1] || set_v[RS_CORE] || set_v[RS_NONSTBY] || set_v[RS_MEM];
    set_v[RS_BUTTON] = s_src[0];
    set_v[RS_RSVD] = 1'b0;
    // Set wins over a same-cycle clear.
    if (wr_rst)
      st_nxt.rst_stat = (st_r.rst_stat & ~io_wdata & RST_STAT_MASK) | set_v;
    else
      st_nxt.rst_stat = (st_r.rst_stat | set_v) & RST_STAT_MASK;
    // A hot condition wins over a shutdown in the same cycle.
    if (s_hot)
      st_nxt.hot_latch = 1'b1;
    else if (s_shut)
      st_nxt.hot_latch = 1'b0;
    if (st_r.boot_cnt == BOOT_SAMPLE)
      st_nxt.jmp_seen = s_jmp;
    else if (s_shut)
      st_nxt.jmp_seen = 1'b0;
    if (st_r.blink_cnt >= BLINK_CNT - 1)
    begin
      st_nxt.blink_cnt = 32'h0000_0000;
      st_nxt.blink_off = s_act ? ~st_r.blink_off : 1'b0;
    end
    else
      st_nxt.blink_cnt = st_r.blink_cnt + 32'h0000_0001;
    if (!s_act)
      st_nxt.blink_off = 1'b0;
    // Automatic colour, most urgent condition first.
    if (st_r.hot_latch || s_hot)
      auto_c = COL_WHITE;
    else if (s_inrst || st_r.jmp_seen)
      auto_c = COL_RED;
    else if (s_stby)
      auto_c = COL_YELLOW;
    else if (s_disk)
      auto_c = COL_BLUE;
    else if (s_l100)
      auto_c = st_r.blink_off ? COL_OFF : COL_MAGENTA;
    else if (s_l10)
      auto_c = st_r.blink_off ? COL_OFF : COL_CYAN;
    else
      auto_c = COL_GREEN;
    if (!s_en)
      col = COL_OFF;
    else if (st_r.led_code[LED_MANUAL_BIT])
      col = st_r.led_code[2:0];
    else
      col = auto_c;
    st_nxt.color = col;
    if (rd_led)
    begin
      st_nxt.rdata = {5'h00, st_r.led_code[2:0]};
      st_nxt.rvalid = 1'b1;
    end
    else if (rd_rst)
    begin
      st_nxt.rdata = st_r.rst_stat;
      st_nxt.rvalid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r.led_code <= LED_CODE_AUTO;
      st_r.rst_stat <= RST_STAT_RESET;
      st_r.hot_latch <= 1'b0;
      st_r.jmp_seen <= 1'b0;
      st_r.boot_cnt <= BOOT_WAIT;
      st_r.blink_off <= 1'b0;
      st_r.blink_cnt <= 32'h0000_0000;
      st_r.color <= COL_OFF;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign io_rdata = st_r.rdata;
  assign io_rdata_valid = st_r.rvalid;
  assign led_red = st_r.color[LED_RED_BIT];
  assign led_green = st_r.color[LED_GREEN_BIT];
  assign led_blue = st_r.color[LED_BLUE_BIT];
endmodule : blrs_top

// [common/blrs_pkg.sv]
/*
 Constants for the board LED and reset status register block.
 Assumes an 8-bit host I/O port access with a 16-bit port address.
*/
package blrs_pkg;
  localparam logic [15:0] LED_CTRL_ADDR = 16'h0456;
  localparam logic [15:0] RST_STAT_ADDR = 16'h0457;
  localparam logic [2:0] LED_FIELD_RESET = 3'h0;
  localparam logic [3:0] LED_CODE_AUTO = 4'h0;
  localparam logic [3:0] LED_CODE_OFF = 4'h8;
  localparam int LED_MANUAL_BIT = 3;
  localparam int LED_BLUE_BIT = 0;
  localparam int LED_GREEN_BIT = 1;
  localparam int LED_RED_BIT = 2;
  localparam logic [2:0] COL_OFF = 3'h0;
  localparam logic [2:0] COL_BLUE = 3'h1;
  localparam logic [2:0] COL_GREEN = 3'h2;
  localparam logic [2:0] COL_CYAN = 3'h3;
  localparam logic [2:0] COL_RED = 3'h4;
  localparam logic [2:0] COL_MAGENTA = 3'h5;
  localparam logic [2:0] COL_YELLOW = 3'h6;
  localparam logic [2:0] COL_WHITE = 3'h7;
  localparam int RS_MAIN = 7;
  localparam int RS_CORE = 6;
  localparam int RS_NONSTBY = 5;
  localparam int RS_MEM = 4;
  localparam int RS_STBY = 3;
  localparam int RS_RSVD = 2;
  localparam int RS_PCI = 1;
  localparam int RS_BUTTON = 0;
  localparam logic [7:0] RST_STAT_RESET = 8'h00;
  localparam logic [7:0] RST_STAT_MASK = 8'hFB;
  localparam int BLINK_MS = 50;
  localparam int CLK_MHZ = 200;
  localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
endpackage : blrs_pkg

// [logic/blrs_sync.sv]
/*
 Two flip-flop synchroniser for a vector of asynchronous levels.
 Assumes the inputs are quasi-static levels; no multi-bit coherency is given.
*/
`timescale 1ns/1ps
module blrs_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : blrs_sync

// [tb/blrs_asserts.sv]
/* Port assertions for the LED and reset status block.
 Assumes a bind to blrs_top with like-named ports. */
`timescale 1ns/1ps
module blrs_asserts
  import blrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  input wire logic led_enable,
  input wire logic led_red,
  input wire logic led_green,
  input wire logic led_blue
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_led_wr;
    io_wr && io_addr == LED_CTRL_ADDR && io_wdata[3] && led_enable && $past(led_enable);
  endsequence
  sequence s_stat_rd;
    io_rd && io_addr == RST_STAT_ADDR ##1 io_rdata_valid;
  endsequence
  a_rd_answer: assert property (io_rd && io_addr[15:1] == 15'h022B |=> io_rdata_valid)
    else $error("read not answered");
  a_valid_cause: assert property (io_rdata_valid
    |-> $past(io_rd && io_addr[15:1] == 15'h022B)) else $error("valid without read");
  a_rdata_hold: assert property (!io_rdata_valid |-> $stable(io_rdata))
    else $error("read data moved");
  a_led_rsvd_zero: assert property (io_rdata_valid && $past(io_addr) == LED_CTRL_ADDR
    |-> io_rdata[7:3] == 5'h00) else $error("LED reserved bits set");
  a_stat_rsvd_zero: assert property (s_stat_rd |-> !io_rdata[RS_RSVD])
    else $error("status reserved bit set");
  a_cascade_bits: assert property (s_stat_rd |-> (!io_rdata[RS_STBY] || io_rdata[7])
    && (!io_rdata[RS_MAIN] || &io_rdata[6:4]) && (!(|io_rdata[7:4]) || io_rdata[RS_PCI]))
    else $error("cascade broken");
  a_led_dark: assert property (!led_enable [*6] |-> !(led_red || led_green || led_blue))
    else $error("LED lit while disabled");
  a_manual_code: assert property (s_led_wr ##1 (led_enable && !io_wr)
    |=> {led_red, led_green, led_blue} == $past(io_wdata[2:0], 2)) else $error("manual colour");
  a_w1c_clear: assert property (io_wr && io_addr == RST_STAT_ADDR && io_wdata == 8'hFF
    ##1 io_rd && io_addr == RST_STAT_ADDR |=> io_rdata == 8'h00) else $error("clear failed");
endmodule : blrs_asserts

// [tb/blrs_top_tb.sv]
/* Self-checking bench for the LED and reset status block.
 Assumes blrs_pkg and blrs_asserts are compiled first. */
`timescale 1ns/1ps
module blrs_top_tb;
  import blrs_pkg::*;
  logic core_clk = 0, rst = 1, io_wr = 0, io_rd = 0, led_enable = 1;
  logic [15:0] io_addr = '0;
  logic [7:0] io_wdata = '0;
  logic [7:0] io_rdata;
  logic io_rdata_valid, led_red, led_green, led_blue;
  logic [8:0] bd = '0;
  logic [6:0] src = '0;
  int n_fail = 0, n_compared = 0, k;
  logic [8:0] bdv [9] = '{9'h000, 9'h080, 9'h040, 9'h100, 9'h008, 9'h004, 9'h084, 9'h020, 9'h0};
  logic [2:0] colv [9] = '{COL_GREEN, COL_BLUE, COL_YELLOW, COL_RED, COL_CYAN, COL_MAGENTA,
    COL_BLUE, COL_WHITE, COL_WHITE};
  logic [7:0] stv [7] = '{8'h01, 8'h02, 8'hFA, 8'h12, 8'h22, 8'h42, 8'hF2};
  blrs_top #(.BLINK_CNT(4)) dut (.core_clk(core_clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .led_enable(led_enable), .board_in_reset(bd[8]),
    .disk_active(bd[7]), .standby(bd[6]), .thermal_near(bd[5]), .system_shutdown(bd[4]),
    .net_link_10(bd[3]), .net_link_100(bd[2]), .net_activity(bd[1]), .defaults_jumper(bd[0]),
    .rst_main_pwr(src[6]), .rst_core_pwr(src[5]), .rst_nonstby_pwr(src[4]),
    .rst_mem_pwr(src[3]), .rst_stby_pwr(src[2]), .rst_pci(src[1]), .button_pressed(src[0]),
    .led_red(led_red), .led_green(led_green), .led_blue(led_blue));
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    tick(1);
    io_wr = 0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1;
    tick(1);
    io_rd = 0;
    chk("valid", {7'h00, a == LED_CTRL_ADDR || a == RST_STAT_ADDR}, {7'h00, io_rdata_valid});
    if (io_rdata_valid === 1'b1) chk("rdata", exp, io_rdata);
  endtask : rd
  task automatic led(input logic [2:0] exp);
    tick(8);
    chk("led", {5'h00, exp}, {5'h00, led_red, led_green, led_blue});
  endtask : led
  task automatic results;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial
  begin
    tick(2);
    rst = 0;
    rd(LED_CTRL_ADDR, 8'h00);
    tick(1);
    rd(RST_STAT_ADDR, 8'h00);
    for (int c = 8; c < 16; c++)
    begin
      wr(LED_CTRL_ADDR, 8'(c));
      led(3'(c));
      rd(LED_CTRL_ADDR, 8'(c) & 8'h07);
    end
    led_enable = 0;
    led(COL_OFF);
    led_enable = 1;
    wr(LED_CTRL_ADDR, 8'h05);
    for (int i = 0; i < 9; i++)
    begin
      bd = bdv[i];
      led(colv[i]);
    end
    bd = 9'h010;
    tick(8);
    bd = '0;
    led(COL_GREEN);
    bd = 9'h00A;
    tick(8);
    k = 0;
    repeat (40)
    begin
      tick(1);
      k += led_blue;
    end
    chk("blink", 8'h01, {7'h00, k > 0 && k < 40});
    bd = '0;
    for (int i = 0; i < 7; i++)
    begin
      src = 7'(1 << i);
      tick(3);
      src = '0;
      tick(4);
      rd(RST_STAT_ADDR, stv[i]);
      wr(RST_STAT_ADDR, (i == 2) ? 8'h08 : 8'hFF);
      rd(RST_STAT_ADDR, (i == 2) ? 8'hF2 : 8'h00);
      wr(RST_STAT_ADDR, 8'hFF);
    end
    wr(16'h0458, 8'hFF);
    rd(16'h0458, 8'h00);
    wr(LED_CTRL_ADDR, 8'h0A);
    led(COL_GREEN);
    bd = 9'h001;
    rst = 1;
    tick(2);
    rst = 0;
    rd(LED_CTRL_ADDR, 8'h00);
    led(COL_RED);
    bd = '0;
    led(COL_RED);
    results();
  end
endmodule : blrs_top_tb
bind blrs_top blrs_asserts u_chk (.core_clk(core_clk), .rst(rst), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rdata_valid(io_rdata_valid), .led_enable(led_enable), .led_red(led_red),
  .led_green(led_green), .led_blue(led_blue));
